// *** rtl/rra_consts.svh ***
/*
 file: address map bases and limits.
 assumes: included by bare name.
*/
`ifndef RRA_CONSTS_SVH
`define RRA_CONSTS_SVH

`define RRA_ADDR_W         40
`define RRA_HBO_BASE       40'hfd_0000_0000
`define RRA_IACK_BASE      40'hfd_f900_0000
`define RRA_SMGT_BASE      40'hfd_f910_0000
`define RRA_RSVA_BASE      40'hfd_f920_0000
`define RRA_RSVB_BASE      40'hfd_f950_0000
`define RRA_XLAT_BASE      40'hfd_fb00_0000
`define RRA_IO_BASE        40'hfd_fc00_0000
`define RRA_CFG_BASE       40'hfd_fe00_0000
`define RRA_XCFG_BASE      40'hfe_0000_0000
`define RRA_RSVC_BASE      40'hfe_2000_0000
`define RRA_HIMEM_BASE     41'h100_0000_0000
`define RRA_CFG_LOW_BYTES  12'h100
`define RRA_WIN_ALIGN_LSB  6
`define RRA_INTR_HINT      8'hf8

`endif

// *** rtl/rra_link_if.sv ***
/*
 file: carrier between requester and routing node.
 assumes: one clock.
*/
`timescale 1ns/1ps

interface rra_link_if
    import rra_pkg::*;
(
    input wire logic clk       // core clock
);
    logic       req_valid;
    logic       req_ready;
    rra_req_t   req;
    logic       rsp_valid;
    logic [4:0] rsp_tag;
    logic       rsp_port;
    logic       rsp_upstream;
    logic       rsp_abort;

    modport dev (
        input  req_valid, req,
        output req_ready, rsp_valid, rsp_tag, rsp_port, rsp_upstream, rsp_abort
    );
    modport req_end (
        output req_valid, req,
        input  req_ready, rsp_valid, rsp_tag, rsp_port, rsp_upstream, rsp_abort
    );
endinterface

// *** rtl/rra_pkg.sv ***
/*
 file: types shared by both ends.
 assumes: consts header on include path.
*/
`include "rra_consts.svh"

package rra_pkg;

    typedef logic [`RRA_ADDR_W-1:0] rra_addr_t;

    typedef enum logic [3:0] {
        RRA_SP_MEM   = 4'h0,
        RRA_SP_INTR  = 4'h1,
        RRA_SP_IACK  = 4'h2,
        RRA_SP_SMGT  = 4'h3,
        RRA_SP_RSV   = 4'h4,
        RRA_SP_XLAT  = 4'h5,
        RRA_SP_IO    = 4'h6,
        RRA_SP_CFG   = 4'h7,
        RRA_SP_XCFG  = 4'h8
    } rra_space_t;

    typedef enum logic [2:0] {
        RRA_CMD_READ   = 3'h0,
        RRA_CMD_WR_NP  = 3'h1,
        RRA_CMD_WR_P   = 3'h2,
        RRA_CMD_BCAST  = 3'h3,
        RRA_CMD_FENCE  = 3'h4,
        RRA_CMD_FLUSH  = 3'h5
    } rra_cmd_t;

    typedef enum logic [3:0] {
        RRA_ACT_ACCEPT  = 4'h0,
        RRA_ACT_FORWARD = 4'h1,
        RRA_ACT_ABORT   = 4'h2,
        RRA_ACT_DEVMSG  = 4'h3
    } rra_action_t;

    typedef enum logic [2:0] {
        RRA_ST_IDLE = 3'b001,
        RRA_ST_REQ  = 3'b010,
        RRA_ST_RSP  = 3'b100
    } rra_state_t;

    typedef struct packed {
        rra_addr_t   addr;
        rra_cmd_t    cmd;
        logic [4:0]  tag;
        logic [3:0]  dwords;
        logic        upstream;
        logic        port;
    } rra_req_t;

    function automatic rra_space_t rra_classify(input rra_addr_t a);
        rra_space_t s;
        s = RRA_SP_MEM;
        if (a >= `RRA_HIMEM_BASE)     s = RRA_SP_MEM;
        else if (a >= `RRA_RSVC_BASE) s = RRA_SP_RSV;
        else if (a >= `RRA_XCFG_BASE) s = RRA_SP_XCFG;
        else if (a >= `RRA_CFG_BASE)  s = RRA_SP_CFG;
        else if (a >= `RRA_IO_BASE)   s = RRA_SP_IO;
        else if (a >= `RRA_XLAT_BASE) s = RRA_SP_XLAT;
        else if (a >= `RRA_RSVA_BASE) s = RRA_SP_RSV;
        else if (a >= `RRA_SMGT_BASE) s = RRA_SP_SMGT;
        else if (a >= `RRA_IACK_BASE) s = RRA_SP_IACK;
        else if (a >= `RRA_HBO_BASE)  s = RRA_SP_INTR;
        return s;
    endfunction

endpackage

// *** rtl/rra_requester.sv ***
/*
 file: requester: shapes user requests per space; one response.
 assumes: user holds usr_valid until usr_ready.
*/
`timescale 1ns/1ps

module rra_requester
    import rra_pkg::*;
(
    input  wire logic       clk,           // core clock
    input  wire logic       resetn,        // sync reset, low
    rra_link_if.req_end     lnk,           // link to routing node
    input  wire logic       usr_valid,     // user request
    output logic            usr_ready,     // request taken
    input  wire rra_addr_t  usr_addr,      // address
    input  wire logic       usr_write,     // write when high
    input  wire logic [3:0] usr_dwords,    // length in dwords
    input  wire logic       usr_upstream,  // request travels upstream
    input  wire logic       usr_peer,      // use direct peer tags
    input  wire logic       mixed_styles,  // both routing styles in use
    input  wire logic [4:0] host_tag,      // tag for host-reflected
    input  wire logic [4:0] peer_tag,      // separate tag for peer style
    output logic            usr_refused,   // illegal, dropped
    output logic            done_valid,    // response seen
    output logic            done_abort     // response was an abort
);

    typedef struct packed {
        logic     busy;
        logic     wait_rsp;
        rra_req_t req;
        logic     ref_p;
        logic     dv;
        logic     da;
    } rra_rq_state_t;

    rra_rq_state_t s_reg, s_next;
    rra_space_t    sp;
    logic          bad;

    assign sp = rra_classify(usr_addr);
    assign bad = (sp == RRA_SP_IACK && (usr_write || usr_upstream))
              || (sp == RRA_SP_RSV && usr_upstream)
              || ((sp == RRA_SP_CFG || sp == RRA_SP_IO) && usr_write
                  && usr_dwords != 4'h1);
    assign usr_ready = !s_reg.busy && !s_reg.wait_rsp;

    always_comb begin
        s_next = s_reg;
        s_next.ref_p = 1'b0;
        s_next.dv = 1'b0;
        if (usr_valid && usr_ready) begin
            if (bad) begin
                s_next.ref_p = 1'b1;
            end else begin
                s_next.busy = 1'b1;
                s_next.req.addr = usr_addr;
                s_next.req.dwords = usr_dwords;
                s_next.req.upstream = usr_upstream;
                s_next.req.port = 1'b0;
                s_next.req.cmd = RRA_CMD_READ;
                if (usr_write) begin
                    if (sp == RRA_SP_INTR || sp == RRA_SP_SMGT)
                        s_next.req.cmd = RRA_CMD_WR_P;
                    else
                        s_next.req.cmd = RRA_CMD_WR_NP;
                end
                // shared tags unless styles mixed
                s_next.req.tag = (usr_peer && mixed_styles) ? peer_tag : host_tag;
            end
        end
        if (s_reg.busy && lnk.req_ready) begin
            s_next.busy = 1'b0;
            s_next.wait_rsp = s_reg.req.cmd != RRA_CMD_WR_P;
        end
        if (s_reg.wait_rsp && lnk.rsp_valid) begin
            s_next.wait_rsp = 1'b0;
            s_next.dv = 1'b1;
            s_next.da = lnk.rsp_abort;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            s_reg <= '{req: '{cmd: RRA_CMD_READ, default: '0}, default: '0};
        end else begin
            s_reg <= s_next;
        end
    end

    assign lnk.req_valid = s_reg.busy;
    assign lnk.req       = s_reg.req;
    assign usr_refused   = s_reg.ref_p;
    assign done_valid    = s_reg.dv;
    assign done_abort    = s_reg.da;

endmodule

// *** rtl/rra_route_dev.sv ***
/*
 file: routing node: space decode, way choice, action, responses.
 assumes: requester keeps per-space write rules.
*/
// Overview of operation
// - default way from config flags
// - fence, flush, top region host-bound
// - host-bound-only always goes default way
// - reverse range hit goes reverse way
// - single-link node uses its only link
// - response leaves on the arrival link
// - response direction opposite to request travel
// - peer response keeps requester tag
// - one routing style shares same tags
// - mixed styles: separate tags
// - base above limit disables the range
// - spaces found by upper address bits
// - interrupt, ack, management forwarded
// - cfg/io writes nonposted, one dword
// - oversized claimed cfg/io access aborted; unclaimed forwarded
// - intr/management writes posted
// - no writes or upstream to ack
// - extended cfg: register or message
// - low 256 config bytes reachable both ways
// - claimed windows aligned on 64 bytes
// - reserved never accepted; forwarded, or aborted at end of chain
// - no upstream access to reserved space
// - interrupts preferably at bits F8h
`timescale 1ns/1ps

module rra_route_dev
    import rra_pkg::*;
#(
    parameter int NRANGE = 2,
    parameter bit SINGLE_LINK = 1'b0
)(
    input  wire logic                   clk,              // core clock
    input  wire logic                   resetn,           // sync reset, low
    rra_link_if.dev                     lnk,              // link
    input  wire logic                   master_side_flag, // master side
    input  wire logic                   preferred_way_flag, // preferred way select
    input  wire logic [NRANGE-1:0]      peer_path_enable, // per-range enable
    input  wire logic [NRANGE-1:0]      range_reverse_flag, // per-range reverse
    input  wire rra_addr_t [NRANGE-1:0] range_base,       // range base
    input  wire rra_addr_t [NRANGE-1:0] range_limit,      // range limit
    input  wire rra_addr_t              win_base,         // claimed window base
    input  wire rra_addr_t              win_limit,        // claimed window limit
    input  wire logic                   is_tunnel,        // node forwards traffic
    output logic                        out_valid,        // routed request pulse
    output rra_addr_t                   out_addr,         // routed address
    output logic                        out_way,          // way link taken: default or reverse way value
    output logic                        out_peer,         // direct peer routed
    output logic                        host_bound_only_class, // classified hbo
    output rra_space_t                  out_space,        // decoded space
    output rra_action_t                 out_action,       // action
    output logic [11:0]                 cfg_offset        // config offset
);

    typedef struct packed {
        rra_state_t  st;
        logic        ov;
        rra_addr_t   addr;
        logic        way;
        logic        peer;
        logic        hbo;
        rra_space_t  sp;
        rra_action_t act;
        logic [11:0] cfgo;
        logic        rv;
        logic [4:0]  rtag;
        logic        rport;
        logic        rup;
        logic        rab;
        logic        npk;
    } rra_dev_state_t;

    rra_dev_state_t s_reg, s_next;
    logic           default_request_way;
    logic           reverse_request_way;
    logic [NRANGE-1:0] hit;
    logic           any_rev_hit;
    logic           claim;
    rra_space_t     sp;
    logic           hbo;
    logic           np;

    assign default_request_way = master_side_flag ^ preferred_way_flag;
    assign reverse_request_way = ~default_request_way;

    genvar g;
    generate
        for (g = 0; g < NRANGE; g++) begin : g_rng
            // base above limit: range disabled
            assign hit[g] = peer_path_enable[g] && range_reverse_flag[g]
                         && (range_base[g] <= range_limit[g])
                         && (lnk.req.addr >= range_base[g])
                         && (lnk.req.addr <= range_limit[g]);
        end
    endgenerate
    assign any_rev_hit = |hit;

    assign sp  = rra_classify(lnk.req.addr);
    assign hbo = (lnk.req.cmd == RRA_CMD_FENCE) || (lnk.req.cmd == RRA_CMD_FLUSH)
              || (lnk.req.addr >= `RRA_HBO_BASE && lnk.req.addr < `RRA_HIMEM_BASE);
    assign np  = (lnk.req.cmd == RRA_CMD_READ) || (lnk.req.cmd == RRA_CMD_WR_NP);
    // windows compared on 64-byte granules
    assign claim = (lnk.req.addr[`RRA_ADDR_W-1:`RRA_WIN_ALIGN_LSB]
                    >= win_base[`RRA_ADDR_W-1:`RRA_WIN_ALIGN_LSB])
                && (lnk.req.addr[`RRA_ADDR_W-1:`RRA_WIN_ALIGN_LSB]
                    <= win_limit[`RRA_ADDR_W-1:`RRA_WIN_ALIGN_LSB]);

    assign lnk.req_ready = s_reg.st[0];

    always_comb begin
        s_next = s_reg;
        s_next.ov = 1'b0;
        s_next.rv = 1'b0;
        case (s_reg.st)
            RRA_ST_IDLE: begin
                if (lnk.req_valid) begin
                    s_next.st   = RRA_ST_REQ;
                    s_next.addr = lnk.req.addr;
                    s_next.sp   = sp;
                    s_next.hbo  = hbo;
                    // kept: the request bus may change once taken
                    s_next.npk  = np;
                    s_next.peer = !hbo && any_rev_hit;
                    if (SINGLE_LINK)
                        s_next.way = default_request_way;
                    else if (hbo)
                        s_next.way = default_request_way;
                    else if (any_rev_hit)
                        s_next.way = reverse_request_way;
                    else
                        s_next.way = default_request_way;
                    s_next.cfgo = {4'h0, lnk.req.addr[7:0]};
                    if (sp == RRA_SP_XCFG)
                        s_next.cfgo = lnk.req.addr[11:0];
                    s_next.act = claim ? RRA_ACT_ACCEPT : RRA_ACT_FORWARD;
                    case (sp)
                        RRA_SP_INTR, RRA_SP_IACK, RRA_SP_SMGT:
                            s_next.act = RRA_ACT_FORWARD;
                        RRA_SP_RSV:
                            s_next.act = RRA_ACT_FORWARD;
                        RRA_SP_CFG, RRA_SP_IO:
                            if (claim && lnk.req.dwords > 4'h1)
                                s_next.act = RRA_ACT_ABORT;
                        RRA_SP_XCFG:
                            if (claim && !np)
                                s_next.act = RRA_ACT_DEVMSG;
                        default: ;
                    endcase
                    // end of chain: reserved space aborts
                    if (!is_tunnel && sp == RRA_SP_RSV)
                        s_next.act = RRA_ACT_ABORT;
                    s_next.rtag  = lnk.req.tag;
                    s_next.rport = lnk.req.port;
                    s_next.rup   = ~lnk.req.upstream;
                    s_next.rab   = 1'b0;
                end
            end
            RRA_ST_REQ: begin
                s_next.ov  = 1'b1;
                s_next.rab = (s_reg.act == RRA_ACT_ABORT);
                s_next.st  = s_reg.npk ? RRA_ST_RSP : RRA_ST_IDLE;
            end
            RRA_ST_RSP: begin
                s_next.rv = 1'b1;
                s_next.st = RRA_ST_IDLE;
            end
            default: s_next.st = RRA_ST_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            s_reg <= '{st: RRA_ST_IDLE, sp: RRA_SP_MEM, act: RRA_ACT_ACCEPT, default: '0};
        end else begin
            s_reg <= s_next;
        end
    end

    assign out_valid             = s_reg.ov;
    assign out_addr              = s_reg.addr;
    assign out_way               = s_reg.way;
    assign out_peer              = s_reg.peer;
    assign host_bound_only_class = s_reg.hbo;
    assign out_space             = s_reg.sp;
    assign out_action            = s_reg.act;
    assign cfg_offset            = s_reg.cfgo;
    assign lnk.rsp_valid         = s_reg.rv;
    assign lnk.rsp_tag           = s_reg.rtag;
    assign lnk.rsp_port          = s_reg.rport;
    assign lnk.rsp_upstream      = s_reg.rup;
    assign lnk.rsp_abort         = s_reg.rab;

endmodule

// *** verification/request_route_addr_decode_bench.sv ***
/*
 file: bench: requester and routing node, plus a bench-fed single-link node.
 assumes: design files and checker compiled first.
*/
`timescale 1ns/1ps

module request_route_addr_decode_bench
    import rra_pkg::*;
;
    localparam rra_addr_t  BT [10] = '{40'hfe_2000_0000, 40'hfe_0000_0000, 40'hfd_fe00_0000,
        40'hfd_fc00_0000, 40'hfd_fb00_0000, 40'hfd_f950_0000, 40'hfd_f920_0000,
        40'hfd_f910_0000, 40'hfd_f900_0000, 40'hfd_0000_0000};
    localparam rra_space_t ST [10] = '{RRA_SP_RSV, RRA_SP_XCFG, RRA_SP_CFG, RRA_SP_IO,
        RRA_SP_XLAT, RRA_SP_RSV, RRA_SP_RSV, RRA_SP_SMGT, RRA_SP_IACK, RRA_SP_INTR};
    localparam rra_addr_t  AT [20] = '{40'h00_0fff_ffff, 40'h00_1000_0000, 40'h00_1fff_ffff,
        40'h00_2000_0000, 40'h00_3800_0000, 40'hfc_ffff_fff0, 40'hfd_0000_0000,
        40'hfd_f800_0000, 40'hfd_f8ff_fff8, 40'hfd_f900_0000, 40'hfd_f910_0000,
        40'hfd_f94f_fffc, 40'hfd_f950_0000, 40'hfd_fbff_fffc, 40'hfd_fc00_0000,
        40'hfd_fe00_0104, 40'hfe_0000_0840, 40'hfe_0000_ffff, 40'hfe_0001_0000,
        40'hfe_2000_0000};
    localparam rra_addr_t  BA [8] = '{40'h00_1000_0040, 40'h00_1800_0000, 40'h00_1000_0000,
        40'hfd_f960_0000, 40'hfd_f900_0000, 40'hfd_fe00_0010, 40'hfe_0000_0040,
        40'hfd_0000_1000};
    localparam rra_cmd_t   BC [8] = '{RRA_CMD_FENCE, RRA_CMD_FLUSH, RRA_CMD_READ, RRA_CMD_READ,
        RRA_CMD_WR_NP, RRA_CMD_WR_P, RRA_CMD_WR_P, RRA_CMD_WR_NP};
    localparam logic [7:0] BU = 8'h1a;

    logic             clk = 1'b0;
    logic             resetn = 1'b0;
    logic             msf, pwf, tun, uv, ur, uw, uu, up, mx, urf, dv, da;
    logic [1:0]       pen, rrev;
    rra_addr_t [1:0]  rb, rl;
    rra_addr_t        wb, wl, ua;
    logic [3:0]       ud;
    logic [4:0]       ht, pt;
    logic             ov [2];
    logic             ow [2];
    logic             ohb [2];
    rra_space_t       osp [2];
    rra_action_t      oac [2];
    logic [11:0]      ocf [2];
    rra_addr_t        oa [2];
    rra_req_t         cap;
    integer           seed = 44575;
    int               n_fail = 0;
    int               total_checks = 0;
    logic [31:0]      r1, r2;

    rra_link_if lnk   (.clk(clk));
    rra_link_if lnk_b (.clk(clk));

    rra_requester i_rra_requester (.clk(clk), .resetn(resetn), .lnk(lnk), .usr_valid(uv),
        .usr_ready(ur), .usr_addr(ua), .usr_write(uw), .usr_dwords(ud), .usr_upstream(uu),
        .usr_peer(up), .mixed_styles(mx), .host_tag(ht), .peer_tag(pt), .usr_refused(urf),
        .done_valid(dv), .done_abort(da));

    rra_route_dev i_rra_route_dev (.clk(clk), .resetn(resetn), .lnk(lnk),
        .master_side_flag(msf), .preferred_way_flag(pwf), .peer_path_enable(pen),
        .range_reverse_flag(rrev), .range_base(rb), .range_limit(rl), .win_base(wb),
        .win_limit(wl), .is_tunnel(tun), .out_valid(ov[0]), .out_addr(oa[0]), .out_way(ow[0]),
        .out_peer(), .host_bound_only_class(ohb[0]), .out_space(osp[0]),
        .out_action(oac[0]), .cfg_offset(ocf[0]));

    // single-link node
    rra_route_dev #(.SINGLE_LINK(1'b1)) i_rra_route_dev_b (.clk(clk), .resetn(resetn),
        .lnk(lnk_b), .master_side_flag(msf), .preferred_way_flag(pwf), .peer_path_enable(pen),
        .range_reverse_flag(rrev), .range_base(rb), .range_limit(rl), .win_base(wb),
        .win_limit(wl), .is_tunnel(tun), .out_valid(ov[1]), .out_addr(oa[1]), .out_way(ow[1]),
        .out_peer(), .host_bound_only_class(ohb[1]), .out_space(osp[1]),
        .out_action(oac[1]), .cfg_offset(ocf[1]));

    rra_route_sva i_rra_route_sva (.clk(clk), .resetn(resetn), .req_valid(lnk.req_valid),
        .req_ready(lnk.req_ready), .req(lnk.req), .rsp_valid(lnk.rsp_valid),
        .rsp_tag(lnk.rsp_tag), .rsp_port(lnk.rsp_port), .rsp_upstream(lnk.rsp_upstream),
        .rsp_abort(lnk.rsp_abort));

    always #12.5 clk = ~clk;

    always @(posedge clk) begin
        if (lnk.req_valid && lnk.req_ready)
            cap <= lnk.req;
    end

    function automatic rra_space_t sp_of(input rra_addr_t a);
        for (int i = 0; i < 10; i++)
            if (a >= BT[i])
                return ST[i];
        return RRA_SP_MEM;
    endfunction

    task automatic cmp(input bit ok, input string m);
        total_checks++;
        if (!ok) begin
            n_fail++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask

    task automatic test_done();
        if (n_fail == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk_dev(input int b, input rra_req_t r, output rra_action_t ea);
        rra_space_t es;
        logic       hbo;
        logic       rev;
        logic       claim;
        logic [8:0] rs;
        int         n;
        for (n = 0; ov[b] !== 1'b1 && n < 10; n++) @(posedge clk) #1;
        es = sp_of(r.addr);
        hbo = r.cmd inside {RRA_CMD_FENCE, RRA_CMD_FLUSH} || r.addr >= 40'hfd_0000_0000;
        rev = 1'b0;
        for (int i = 0; i < 2; i++)
            if (pen[i] && rrev[i] && rb[i] <= rl[i] && r.addr >= rb[i] && r.addr <= rl[i])
                rev = 1'b1;
        claim = r.addr[39:6] >= wb[39:6] && r.addr[39:6] <= wl[39:6];
        ea = claim ? RRA_ACT_ACCEPT : RRA_ACT_FORWARD;
        if (es inside {RRA_SP_INTR, RRA_SP_IACK, RRA_SP_SMGT})
            ea = RRA_ACT_FORWARD;
        else if (es == RRA_SP_RSV)
            ea = tun ? RRA_ACT_FORWARD : RRA_ACT_ABORT;
        else if (claim && es inside {RRA_SP_CFG, RRA_SP_IO} && r.dwords > 4'h1)
            ea = RRA_ACT_ABORT;
        else if (claim && es == RRA_SP_XCFG && r.cmd == RRA_CMD_WR_P)
            ea = RRA_ACT_DEVMSG;
        cmp(ov[b] === 1'b1 && oa[b] === r.addr, "routed");
        cmp(ow[b] === (msf ^ pwf ^ (rev && !hbo && b == 0)), "way");
        cmp(ohb[b] === hbo, "hbo");
        cmp(osp[b] === es, "space");
        cmp(oac[b] === ea, "action");
        if (es inside {RRA_SP_CFG, RRA_SP_XCFG})
            cmp(ocf[b] === (es == RRA_SP_CFG ? {4'h0, r.addr[7:0]} : r.addr[11:0]), "offset");
        if (r.cmd inside {RRA_CMD_READ, RRA_CMD_WR_NP}) begin
            @(posedge clk);
            #1;
            rs = (b != 0) ? {lnk_b.rsp_valid, lnk_b.rsp_abort, lnk_b.rsp_port,
                lnk_b.rsp_upstream, lnk_b.rsp_tag} : {lnk.rsp_valid, lnk.rsp_abort,
                lnk.rsp_port, lnk.rsp_upstream, lnk.rsp_tag};
            cmp(rs === {1'b1, ea == RRA_ACT_ABORT, r.port, !r.upstream, r.tag}, "response");
        end
    endtask

    // f: 0 write, 3:2 extra dwords, 4 up, 5 peer, 6 mixed
    task automatic send(input rra_addr_t a, input logic [31:0] f);
        rra_space_t  s;
        logic        refuse;
        rra_action_t ea;
        int          n;
        s = sp_of(a);
        refuse = (s == RRA_SP_IACK && (f[0] || f[4])) || (s == RRA_SP_RSV && f[4])
              || (s inside {RRA_SP_CFG, RRA_SP_IO} && f[0] && f[3:2] != 2'b00);
        @(negedge clk);
        {uv, uw, uu, up, mx} = {1'b1, f[0], f[4], f[5], f[6]};
        ua = a;
        ud = 4'h1 + {2'b00, f[3:2]};
        #1;
        for (n = 0; ur !== 1'b1 && n < 20; n++) @(negedge clk) #1;
        @(negedge clk);
        uv = 1'b0;
        for (n = 0; urf !== 1'b1 && ov[0] !== 1'b1 && n < 10; n++) @(posedge clk) #1;
        cmp(urf === refuse, "refusal");
        if (!refuse) begin
            cmp(cap.tag === ((f[5] && f[6]) ? pt : ht), "tag");
            cmp(cap.addr === a && cap.upstream === f[4] && cap.dwords === ud, "request");
            if (!f[0])
                cmp(cap.cmd === RRA_CMD_READ, "read kind");
            else if (s inside {RRA_SP_CFG, RRA_SP_IO})
                cmp(cap.cmd === RRA_CMD_WR_NP, "cfg write");
            else if (s inside {RRA_SP_INTR, RRA_SP_SMGT})
                cmp(cap.cmd === RRA_CMD_WR_P, "posted");
            chk_dev(0, cap, ea);
            if (cap.cmd inside {RRA_CMD_READ, RRA_CMD_WR_NP}) begin
                for (n = 0; dv !== 1'b1 && n < 4; n++) @(posedge clk) #1;
                cmp(dv === 1'b1 && da === (ea == RRA_ACT_ABORT), "done");
            end
        end
    endtask

    // drives the second link; released fields are inverted
    task automatic bad(input rra_addr_t a, input rra_cmd_t c, input logic u);
        rra_req_t    r;
        rra_action_t ea;
        int          n;
        r = '{addr: a, cmd: c, tag: 5'h09, dwords: 4'h1, upstream: u, port: 1'b1};
        @(negedge clk);
        lnk_b.req_valid = 1'b1;
        lnk_b.req = r;
        #1;
        for (n = 0; lnk_b.req_ready !== 1'b1 && n < 20; n++) @(negedge clk) #1;
        @(negedge clk);
        lnk_b.req_valid = 1'b0;
        lnk_b.req = rra_req_t'(~r);
        chk_dev(1, r, ea);
    endtask

    initial begin
        {uv, uw, uu, up, mx, msf, pwf, tun} = '0;
        ua = '0;
        ud = 4'h1;
        ht = 5'h03;
        pt = 5'h11;
        pen = 2'b11;
        rrev = 2'b11;
        rb = {40'h00_3000_0000, 40'h00_1000_0000};
        rl = {40'h00_2000_0000, 40'h00_1fff_ffff};
        wb = 40'hfd_fc00_0000;
        wl = 40'hfe_0000_ffc0;
        lnk_b.req_valid = 1'b0;
        lnk_b.req = '0;
        repeat (20) @(negedge clk);
        resetn = 1'b1;
        for (int ph = 0; ph < 4; ph++) begin
            @(negedge clk);
            {pwf, msf} = ph[1:0];
            tun = ph[0];
            rrev[0] = (ph != 2);
            pen[0] = (ph != 3);
            rl[0] = ph[1] ? 40'hfd_ffff_ffff : 40'h00_1fff_ffff;
            foreach (AT[k]) send(AT[k], $random(seed));
            repeat (8) begin
                r1 = $random(seed);
                r2 = $random(seed);
                send({r2[9] ? 8'hfd : 8'h00, r1}, r2);
            end
            foreach (BA[k]) bad(BA[k], BC[k], BU[k]);
        end
        test_done();
    end

    initial begin
        #250000;
        cmp(1'b0, "watchdog");
        test_done();
    end
endmodule

// *** verification/rra_route_sva.sv ***
/*
 file: concurrent checks on the request link.
 assumes: one bench instance; sync low reset.
*/
`timescale 1ns/1ps
`include "rra_consts.svh"

module rra_route_sva
    import rra_pkg::*;
(
    input wire logic       clk,          // core clock
    input wire logic       resetn,       // sync reset, low
    input wire logic       req_valid,    // request offered
    input wire logic       req_ready,    // routing node idle
    input wire rra_req_t   req,          // request fields
    input wire logic       rsp_valid,    // response pulse
    input wire logic [4:0] rsp_tag,      // response source tag
    input wire logic       rsp_port,     // response link
    input wire logic       rsp_upstream, // response travel
    input wire logic       rsp_abort     // response is an abort
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    logic take;
    logic np_take;
    logic wr;
    logic in_iack;
    logic in_rsv;
    logic in_cfgio;
    logic in_post;

    assign take     = req_valid && req_ready;
    assign np_take  = take && (req.cmd == RRA_CMD_READ || req.cmd == RRA_CMD_WR_NP);
    assign wr       = req.cmd inside {RRA_CMD_WR_NP, RRA_CMD_WR_P, RRA_CMD_BCAST};
    assign in_iack  = req.addr >= `RRA_IACK_BASE && req.addr < `RRA_SMGT_BASE;
    assign in_rsv   = (req.addr >= `RRA_RSVA_BASE && req.addr < `RRA_XLAT_BASE)
                   || req.addr >= `RRA_RSVC_BASE;
    assign in_cfgio = req.addr >= `RRA_IO_BASE && req.addr < `RRA_XCFG_BASE;
    assign in_post  = (req.addr >= `RRA_HBO_BASE && req.addr < `RRA_IACK_BASE)
                   || (req.addr >= `RRA_SMGT_BASE && req.addr < `RRA_RSVA_BASE);

    sequence s_take;    take;                            endsequence
    sequence s_np_take; np_take;                         endsequence
    sequence s_p_take;  take && req.cmd == RRA_CMD_WR_P; endsequence

    property p_busy;  s_take |=> !req_ready; endproperty
    property p_hold;  req_valid && !req_ready |=> req_valid && $stable(req); endproperty
    property p_rsp;
        s_np_take |-> ##3 rsp_valid && rsp_upstream == !$past(req.upstream, 3)
                              && rsp_tag == $past(req.tag, 3);
    endproperty
    property p_port;  s_np_take |-> ##3 rsp_port == $past(req.port, 3); endproperty
    property p_quiet; s_p_take |=> !rsp_valid [*3]; endproperty
    property p_cause; rsp_valid |-> $past(np_take, 3); endproperty
    property p_iack;  req_valid && in_iack |-> !wr && !req.upstream; endproperty
    property p_rsv;   req_valid && in_rsv |-> !req.upstream; endproperty
    property p_cfgio;
        req_valid && in_cfgio && wr |-> req.cmd == RRA_CMD_WR_NP && req.dwords == 4'h1;
    endproperty
    property p_intr;  req_valid && in_post && wr |-> req.cmd == RRA_CMD_WR_P; endproperty

    a_busy:  assert property (p_busy) else $error("ready after take");
    a_hold:  assert property (p_hold) else $error("request not held");
    a_rsp:   assert property (p_rsp) else $error("bad response");
    a_port:  assert property (p_port) else $error("wrong response link");
    a_quiet: assert property (p_quiet) else $error("posted got response");
    a_cause: assert property (p_cause) else $error("stray response");
    a_iack:  assert property (p_iack) else $error("bad ack access");
    a_rsv:   assert property (p_rsv) else $error("upstream reserved");
    a_cfgio: assert property (p_cfgio) else $error("bad cfg/io write");
    a_intr:  assert property (p_intr) else $error("nonposted intr write");

    c_abort: cover property (rsp_valid && rsp_abort);
endmodule
